// ==== bench/tb_top.sv ====
// self-checking bench of the firmware lockup watchdog
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
    $display("mismatch at %0t got %0h exp %0h", $time, got, exp); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import fwlw_pkg::*;
    logic core_clk;
    logic sys_rst;
    logic prescale_tick;
    logic timeout_length_wr;
    logic arm_kick_wr;
    fwlw_byte_t wr_data;
    fwlw_byte_t timeout_length_rd_data;
    fwlw_byte_t arm_kick_rd_data;
    logic wdog_active;
    logic core_reset;
    logic board_reset_output;
    int fail_count = 0;
    int comparisons = 0;
    fwlw_watchdog i_fwlw_watchdog (
        .core_clk(core_clk), .sys_rst(sys_rst), .prescale_tick(prescale_tick),
        .timeout_length_wr(timeout_length_wr), .arm_kick_wr(arm_kick_wr), .wr_data(wr_data),
        .timeout_length_rd_data(timeout_length_rd_data), .arm_kick_rd_data(arm_kick_rd_data),
        .wdog_active(wdog_active), .core_reset(core_reset),
        .board_reset_output(board_reset_output)
    );
    always #2 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////////
    // one write strobe; a gap cycle follows so a strobe is never set twice at once
    task automatic wr(input logic to_kick, input fwlw_byte_t b);
        @(posedge core_clk) #1;
        timeout_length_wr = !to_kick;
        arm_kick_wr = to_kick;
        wr_data = b;
        @(posedge core_clk) #1;
        timeout_length_wr = 1'b0;
        arm_kick_wr = 1'b0;
        wr_data = ~b;
    endtask
    // eight prescaler pulses make one 1 ms tick
    task automatic ms_tick();
        repeat (8) begin
            @(posedge core_clk) #1 prescale_tick = 1'b1;
            @(posedge core_clk) #1 prescale_tick = 1'b0;
        end
    endtask
    task automatic do_reset();
        @(posedge core_clk) #1 sys_rst = 1'b1;
        repeat (2) @(posedge core_clk);
        #1 sys_rst = 1'b0;
    endtask
    task automatic kick();
        wr(1'b1, 8'h0F);
        wr(1'b1, 8'hF0);
    endtask
    // called right after the tick that should fire
    task automatic chk_fire();
        `CHK(core_reset, 1'b1)
        for (int i = 0; i < 8; i++) begin
            `CHK(core_reset, 1'b1)
            `CHK(board_reset_output, 1'b1)
            @(posedge core_clk) #1;
        end
        `CHK({core_reset, board_reset_output}, 2'b00)
        `CHK(wdog_active, 1'b0)
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_state();
        `CHK(timeout_length_rd_data, 8'h00)
        `CHK(arm_kick_rd_data, 8'h00)
        `CHK({wdog_active, core_reset, board_reset_output}, 3'b000)
    endtask
    task automatic t_arm_order();
        kick();
        `CHK(wdog_active, 1'b0)
        wr(1'b0, 8'h03);
        wr(1'b0, 8'h05);
        `CHK(timeout_length_rd_data, 8'h03)
        wr(1'b1, 8'hF0);
        `CHK(wdog_active, 1'b0)
        wr(1'b1, 8'h0F);
        wr(1'b1, 8'h55);
        wr(1'b1, 8'h0F);
        `CHK(wdog_active, 1'b0)
        wr(1'b1, 8'hF0);
        `CHK(wdog_active, 1'b1)
        `CHK(arm_kick_rd_data, 8'h00)
        wr(1'b0, 8'h09);
        `CHK(timeout_length_rd_data, 8'h03)
    endtask
    // interval n expires on tick n+1 after arming
    task automatic t_expiry(input fwlw_byte_t n);
        do_reset();
        wr(1'b0, n);
        kick();
        `CHK(wdog_active, 1'b1)
        for (int i = 0; i < n; i++) begin
            ms_tick();
            `CHK(core_reset, 1'b0)
        end
        ms_tick();
        chk_fire();
        `CHK(timeout_length_rd_data, 8'h00)
    endtask
    task automatic t_retrigger();
        do_reset();
        wr(1'b0, 8'h02);
        kick();
        ms_tick();
        ms_tick();
        kick();
        ms_tick();
        ms_tick();
        `CHK(core_reset, 1'b0)
        wr(1'b0, 8'h00);
        wr(1'b1, 8'h00);
        `CHK(wdog_active, 1'b1)
        ms_tick();
        chk_fire();
        wr(1'b0, 8'h04);
        kick();
        do_reset();
        `CHK(wdog_active, 1'b0)
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #40000;
        fail_count++;
        final_report();
    end
    initial begin
        core_clk = 1'b0;
        sys_rst = 1'b1;
        prescale_tick = 1'b0;
        timeout_length_wr = 1'b0;
        arm_kick_wr = 1'b0;
        wr_data = 8'h00;
        repeat (20) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        t_reset_state();
        t_arm_order();
        t_expiry(8'h00);
        t_expiry(8'h03);
        t_retrigger();
        final_report();
    end
endmodule

// ==== design/fwlw_defs.svh ====
// constants of the firmware lockup watchdog
`ifndef FWLW_DEFS_SVH
`define FWLW_DEFS_SVH
`define FWLW_KEY_FIRST 8'h0F
`define FWLW_KEY_SECOND 8'hF0
`define FWLW_KICK_READ_VALUE 8'h00
`define FWLW_INTERVAL_RESET 8'h00
`define FWLW_PRESCALE_PER_MS 4'h8
`define FWLW_PUD_CYCLES 4'h8
`endif

// ==== design/fwlw_pkg.sv ====
// types of the firmware lockup watchdog
package fwlw_pkg;
    typedef logic [7:0] fwlw_byte_t;
    typedef enum logic [0:0] {
        KEY_IDLE = 1'b0,
        KEY_GOT_FIRST = 1'b1
    } fwlw_key_state_e;
endpackage

// ==== design/fwlw_pud_timer.sv ====
// power-up delay timer that stretches the watchdog reset
`include "fwlw_defs.svh"
module fwlw_pud_timer #(
    parameter logic [3:0] CYCLES = `FWLW_PUD_CYCLES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic start,
    output logic busy
);
    logic [3:0] remaining;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            busy <= 1'b0;
            remaining <= 4'h0;
        end else if (start) begin
            busy <= 1'b1;
            remaining <= CYCLES - 4'h1;
        end else if (busy) begin
            if (remaining == 4'h0) begin
                busy <= 1'b0;
            end else begin
                remaining <= remaining - 4'h1;
            end
        end
    end
endmodule

// ==== design/fwlw_watchdog.sv ====
// firmware lockup watchdog: locked interval, two-byte key, 1 ms countdown, reset stretch
//
// Functional notes
// - watchdog is inactive after reset until the whole arming sequence completes
// - once active, no write deactivates it; only a reset does
// - only the first interval write is kept; key sequence waits for it
// - key is 0x0F then 0xF0 to arm/kick; other orders are ignored
// - completing the arming sequence loads the stored interval into the counter
// - the counter starts counting as soon as the watchdog is active
// - counter decrements per 1 ms tick, eight 125 us prescaler pulses, clock edge
// - after the counter reaches zero, watchdog reset fires at the next tick
// - watchdog reset drives core reset and board reset output at once
// - both resets stay active for 8 clock cycles, then release
// - each 0x0F then 0xF0 retrigger reloads the counter from the interval
// - interval N gives a timeout of N+1 ticks of 1 ms
// - arm/kick register always reads 0x00
// - interval register reads back the programmed value
// - any other data, repeated 0x0F or repeated 0xF0, is ignored
`include "fwlw_defs.svh"
module fwlw_watchdog #(
    parameter logic [3:0] PRESCALE_PER_MS = `FWLW_PRESCALE_PER_MS
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic prescale_tick,
    input wire logic timeout_length_wr,
    input wire logic arm_kick_wr,
    input wire fwlw_pkg::fwlw_byte_t wr_data,
    output fwlw_pkg::fwlw_byte_t timeout_length_rd_data,
    output fwlw_pkg::fwlw_byte_t arm_kick_rd_data,
    output logic wdog_active,
    output logic core_reset,
    output logic board_reset_output
);
    import fwlw_pkg::*;

    fwlw_byte_t interval;
    fwlw_byte_t count;
    logic interval_locked;
    fwlw_key_state_e key_state;
    logic [3:0] prescale_div;
    logic ms_tick;
    logic key_done;
    logic wdog_fire;
    logic pud_busy;

    ////////////////////////////////////////////////////////////////////////////
    // interval register, locked after the first write

    always_ff @(posedge core_clk) begin
        if (sys_rst || wdog_fire) begin
            interval <= `FWLW_INTERVAL_RESET;
            interval_locked <= 1'b0;
        end else if (timeout_length_wr && !interval_locked) begin
            interval <= wr_data;
            interval_locked <= 1'b1;
        end
    end

    assign timeout_length_rd_data = interval;
    assign arm_kick_rd_data = `FWLW_KICK_READ_VALUE;

    ////////////////////////////////////////////////////////////////////////////
    // key sequence; bytes between the two key bytes leave the state alone

    assign key_done = arm_kick_wr && interval_locked && key_state == KEY_GOT_FIRST
        && wr_data == `FWLW_KEY_SECOND;

    always_ff @(posedge core_clk) begin
        if (sys_rst || wdog_fire) begin
            key_state <= KEY_IDLE;
        end else if (arm_kick_wr && interval_locked) begin
            case (key_state)
                KEY_IDLE: begin
                    if (wr_data == `FWLW_KEY_FIRST) begin
                        key_state <= KEY_GOT_FIRST;
                    end
                end
                KEY_GOT_FIRST: begin
                    // any other byte, repeated first key too, leaves the first key pending
                    if (wr_data == `FWLW_KEY_SECOND) begin
                        key_state <= KEY_IDLE;
                    end
                end
                default: begin
                    key_state <= KEY_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // 1 ms tick; free running, so the first timeout carries up to 1 ms of slack

    assign ms_tick = prescale_tick && prescale_div == PRESCALE_PER_MS - 4'h1;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prescale_div <= 4'h0;
        end else if (ms_tick) begin
            prescale_div <= 4'h0;
        end else if (prescale_tick) begin
            prescale_div <= prescale_div + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // activity and down counter; a retrigger beats a tick in the same cycle

    assign wdog_fire = wdog_active && ms_tick && count == 8'h00 && !key_done;

    always_ff @(posedge core_clk) begin
        if (sys_rst || wdog_fire) begin
            wdog_active <= 1'b0;
        end else if (key_done) begin
            wdog_active <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            count <= 8'h00;
        end else if (key_done) begin
            count <= interval;
        end else if (wdog_active && ms_tick && count != 8'h00) begin
            count <= count - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset stretch

    fwlw_pud_timer #(
        .CYCLES(`FWLW_PUD_CYCLES)
    ) u_pud (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .start(wdog_fire),
        .busy(pud_busy)
    );

    // the watchdog clears itself with the core reset, so arming starts over
    assign core_reset = pud_busy;
    assign board_reset_output = pud_busy;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    property p_inactive_after_reset;
        @(posedge core_clk) sys_rst |=> !wdog_active;
    endproperty
    a_inactive_after_reset: assert property (p_inactive_after_reset)
        else $error("watchdog active right after reset");

    property p_stays_active;
        @(posedge core_clk) disable iff (sys_rst)
        wdog_active && !wdog_fire |=> wdog_active;
    endproperty
    a_stays_active: assert property (p_stays_active)
        else $error("watchdog left active state without reset");

    property p_interval_locked;
        @(posedge core_clk) disable iff (sys_rst)
        interval_locked && !wdog_fire |=> interval == $past(interval);
    endproperty
    a_interval_locked: assert property (p_interval_locked)
        else $error("locked interval changed");

    property p_arm_loads;
        @(posedge core_clk) disable iff (sys_rst)
        key_done && !wdog_active |=> wdog_active && count == $past(interval);
    endproperty
    a_arm_loads: assert property (p_arm_loads)
        else $error("arming did not load interval");

    property p_kick_reloads;
        @(posedge core_clk) disable iff (sys_rst)
        key_done && wdog_active |=> count == $past(interval) && wdog_active;
    endproperty
    a_kick_reloads: assert property (p_kick_reloads)
        else $error("retrigger did not reload counter");

    property p_decrement;
        @(posedge core_clk) disable iff (sys_rst)
        wdog_active && ms_tick && count != 8'h00 && !key_done
        |=> count == $past(count) - 8'h01;
    endproperty
    a_decrement: assert property (p_decrement)
        else $error("counter did not decrement on tick");

    // pulses counted apart from the divider, so a broken divider shows up
    logic [4:0] pulses_seen;

    always_ff @(posedge core_clk) begin
        if (sys_rst || ms_tick) begin
            pulses_seen <= 5'h00;
        end else if (prescale_tick && pulses_seen != 5'h1F) begin
            pulses_seen <= pulses_seen + 5'h01;
        end
    end

    property p_tick_spacing;
        @(posedge core_clk) disable iff (sys_rst)
        ms_tick |-> prescale_tick && pulses_seen == {1'b0, PRESCALE_PER_MS - 4'h1};
    endproperty
    a_tick_spacing: assert property (p_tick_spacing)
        else $error("ms tick not on eighth prescaler pulse");

    property p_fire_on_zero;
        @(posedge core_clk) disable iff (sys_rst)
        wdog_active && ms_tick && count == 8'h00 && !key_done |=> core_reset;
    endproperty
    a_fire_on_zero: assert property (p_fire_on_zero)
        else $error("no watchdog reset after zero and tick");

    property p_reset_stretch;
        @(posedge core_clk) disable iff (sys_rst)
        wdog_fire |=> core_reset [*8] ##1 !core_reset;
    endproperty
    a_reset_stretch: assert property (p_reset_stretch)
        else $error("reset stretch not 8 cycles");

    property p_resets_together;
        @(posedge core_clk) core_reset == board_reset_output;
    endproperty
    a_resets_together: assert property (p_resets_together)
        else $error("core and board reset differ");

    property p_kick_reads_zero;
        @(posedge core_clk) arm_kick_rd_data == 8'h00;
    endproperty
    a_kick_reads_zero: assert property (p_kick_reads_zero)
        else $error("arm kick read not zero");

    property p_ignore_other;
        @(posedge core_clk) disable iff (sys_rst)
        arm_kick_wr && wr_data != 8'hF0 |-> !key_done;
    endproperty
    a_ignore_other: assert property (p_ignore_other)
        else $error("key completed without second key byte");
endmodule
